// >>> logic/sil_status.sv
// SCSI ID capture, selection checks and error LED blinker
`timescale 1ns/1ps
`include "sil_map.svh"
module sil_status import sil_pkg::*; #(
	parameter int unsigned ONE_CYC = `SIL_CYC(`SIL_T_ONE_MS),
	parameter int unsigned ZERO_CYC = `SIL_CYC(`SIL_T_ZERO_MS),
	parameter int unsigned GAP_CYC = `SIL_CYC(`SIL_T_GAP_MS),
	parameter int unsigned BREAK_CYC = `SIL_CYC(`SIL_T_BREAK_MS)
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Switch block pins, sw[3] is switch 1
	input wire logic [3:0] sw,
	// Diagnostics sequencer
	input wire logic diag_active,
	input wire logic diag_fail,
	input wire logic [1:0] diag_code,
	// Selection check, one-cycle strobe with bus snapshot
	input wire logic sel_check,
	input wire logic [7:0] sel_data,
	input wire logic sel_line,
	input wire logic flag_err,
	input wire logic enhanced,
	input wire logic parity_err,
	input wire logic sel_flag,
	// Results
	output logic [7:0] id_mask,
	output logic led_on,
	output logic err_active,
	output logic [3:0] err_code
);
	// ****************************************
	// Switch capture
	// ****************************************
	logic [3:0] sw_s;
	logic [7:0] mask_w;
	logic [2:0] id_r, id_nxt;
	logic [7:0] mask_r, mask_nxt;

	sil_sync #(.W(4)) u_sync (
		.sys_clk(sys_clk),
		.srst(srst),
		.din(sw),
		.dout(sw_s)
	);

	sil_onehot u_hot (
		.id(id_r),
		.mask(mask_w)
	);

	always_comb begin
		id_nxt = id_r;
		mask_nxt = mask_w;
		if (diag_active) begin
			id_nxt = sw_s[3:1];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			id_r <= 3'h0;
			mask_r <= 8'h01;
		end else begin
			id_r <= id_nxt;
			mask_r <= mask_nxt;
		end
	end

	// ****************************************
	// Fault detection
	// ****************************************
	function automatic logic [3:0] pop8(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

	logic fault;
	sil_code_t fault_code;

	always_comb begin
		fault = 1'b0;
		fault_code = 4'h0;
		if (diag_active && diag_fail) begin
			fault = 1'b1;
			fault_code = {2'b00, diag_code};
		end else if (!diag_active && sel_check) begin
			fault = 1'b1;
			// Checks in the order the controller reports them
			if (!enhanced && flag_err) begin
				fault_code = `SIL_ERR_FLAG;
			end else if (!enhanced && !sel_line) begin
				fault_code = `SIL_ERR_SEL_LOW;
			end else if ((sel_data & mask_r) == 8'h00) begin
				fault_code = `SIL_ERR_OWN_ID;
			end else if (pop8(sel_data) > 4'h2) begin
				fault_code = `SIL_ERR_MANY;
			end else if (enhanced && parity_err) begin
				fault_code = `SIL_ERR_PARITY;
			end else if (enhanced && !sel_flag) begin
				fault_code = `SIL_ERR_SEL_FLAG;
			end else begin
				fault = 1'b0;
			end
		end
	end

	// ****************************************
	// LED sequencer
	// ****************************************
	sil_led_e st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [1:0] bit_r, bit_nxt;
	sil_code_t code_r, code_nxt;
	logic led_r, led_nxt;
	logic err_r, err_nxt;

	function automatic logic [31:0] dark_len(input logic b);
		return b ? 32'(ONE_CYC) : 32'(ZERO_CYC);
	endfunction

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		bit_nxt = bit_r;
		code_nxt = code_r;
		err_nxt = err_r;
		unique case (st_r)
			SIL_BOOT: begin
				st_nxt = SIL_RUN;
			end
			SIL_RUN: begin
				if (fault) begin
					// Latched once, only reset leaves error signalling
					code_nxt = fault_code;
					err_nxt = 1'b1;
					bit_nxt = 2'd3;
					cnt_nxt = dark_len(fault_code[`SIL_CODE_MSB]) - 32'd1;
					st_nxt = SIL_DARK;
				end
			end
			SIL_DARK: begin
				if (cnt_r == 32'd0) begin
					if (bit_r == 2'd0) begin
						cnt_nxt = 32'(BREAK_CYC) - 32'd1;
						st_nxt = SIL_BREAK;
					end else begin
						cnt_nxt = 32'(GAP_CYC) - 32'd1;
						st_nxt = SIL_GAP;
					end
				end else begin
					cnt_nxt = cnt_r - 32'd1;
				end
			end
			SIL_GAP: begin
				if (cnt_r == 32'd0) begin
					bit_nxt = bit_r - 2'd1;
					cnt_nxt = dark_len(code_r[bit_r - 2'd1]) - 32'd1;
					st_nxt = SIL_DARK;
				end else begin
					cnt_nxt = cnt_r - 32'd1;
				end
			end
			SIL_BREAK: begin
				if (cnt_r == 32'd0) begin
					bit_nxt = 2'd3;
					cnt_nxt = dark_len(code_r[`SIL_CODE_MSB]) - 32'd1;
					st_nxt = SIL_DARK;
				end else begin
					cnt_nxt = cnt_r - 32'd1;
				end
			end
			default: begin
				st_nxt = SIL_RUN;
			end
		endcase
		led_nxt = (st_nxt != SIL_DARK);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_r <= SIL_BOOT;
			cnt_r <= 32'd0;
			bit_r <= 2'd0;
			code_r <= 4'h0;
			led_r <= 1'b1;
			err_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			code_r <= code_nxt;
			led_r <= led_nxt;
			err_r <= err_nxt;
		end
	end

	assign id_mask = mask_r;
	assign led_on = led_r;
	assign err_active = err_r;
	assign err_code = code_r;

	// ****************************************
	// Checks
	// ****************************************
	property p_onehot;
		@(posedge sys_clk) disable iff (srst)
		##1 (mask_r == (8'h01 << $past(id_r)));
	endproperty
	a_onehot: assert property (p_onehot) else $error("id mask not one-hot of id");

	property p_id_frozen;
		@(posedge sys_clk) disable iff (srst)
		!diag_active |=> $stable(id_r);
	endproperty
	a_id_frozen: assert property (p_id_frozen) else $error("id changed after diagnostics");

	property p_id_take;
		@(posedge sys_clk) disable iff (srst)
		diag_active |=> (id_r == $past(sw_s[3:1]));
	endproperty
	a_id_take: assert property (p_id_take) else $error("id not from switches 1 to 3");

	property p_sticky;
		@(posedge sys_clk) disable iff (srst)
		err_r |=> (err_r && $stable(code_r));
	endproperty
	a_sticky: assert property (p_sticky) else $error("error signalling stopped");

	property p_lit_ok;
		@(posedge sys_clk) disable iff (srst)
		!err_r |-> led_r;
	endproperty
	a_lit_ok: assert property (p_lit_ok) else $error("led dark without error");

	property p_start;
		@(posedge sys_clk) disable iff (srst)
		(st_r == SIL_RUN && fault) |=> (err_r && !led_r && bit_r == 2'd3);
	endproperty
	a_start: assert property (p_start) else $error("fault did not start msb dark");

	property p_diag_code;
		@(posedge sys_clk) disable iff (srst)
		(st_r == SIL_RUN && diag_active && diag_fail) |=> (code_r[3:2] == 2'b00);
	endproperty
	a_diag_code: assert property (p_diag_code) else $error("diagnostic code above 3");

	property p_many;
		@(posedge sys_clk) disable iff (srst)
		(st_r == SIL_RUN && !diag_active && sel_check && (enhanced || (!flag_err && sel_line))
		 && (sel_data & mask_r) != 8'h00 && pop8(sel_data) > 4'h2)
		|=> (code_r == `SIL_ERR_MANY);
	endproperty
	a_many: assert property (p_many) else $error("too many bus bits not code 7");

	property p_gap_len;
		@(posedge sys_clk) disable iff (srst)
		(st_r == SIL_DARK && cnt_r == 32'd0 && bit_r != 2'd0) |=> led_r [*2];
	endproperty
	a_gap_len: assert property (p_gap_len) else $error("gap shorter than expected");

	property p_dark_hold;
		@(posedge sys_clk) disable iff (srst)
		(st_r == SIL_RUN && fault) |=> (!led_r) [*2];
	endproperty
	a_dark_hold: assert property (p_dark_hold) else $error("first dark too short");

	property p_break_len;
		@(posedge sys_clk) disable iff (srst)
		(st_r == SIL_DARK && cnt_r == 32'd0 && bit_r == 2'd0) |=> led_r [*2];
	endproperty
	a_break_len: assert property (p_break_len) else $error("break too short");

	property p_own_id;
		@(posedge sys_clk) disable iff (srst)
		(st_r == SIL_RUN && !diag_active && sel_check && (enhanced || (!flag_err && sel_line))
		 && (sel_data & mask_r) == 8'h00)
		|=> (code_r == `SIL_ERR_OWN_ID);
	endproperty
	a_own_id: assert property (p_own_id) else $error("own id bit missing not code 6");

	// Enhanced part leaves the basic flag and select line unread
	property p_enh_pass;
		@(posedge sys_clk) disable iff (srst)
		(st_r == SIL_RUN && !diag_active && sel_check && enhanced && !parity_err && sel_flag
		 && (sel_data & mask_r) != 8'h00 && pop8(sel_data) <= 4'h2)
		|=> !err_r;
	endproperty
	a_enh_pass: assert property (p_enh_pass) else $error("enhanced pass flagged");

	property p_diag_quiet;
		@(posedge sys_clk) disable iff (srst)
		(st_r == SIL_RUN && diag_active && !diag_fail) |=> !err_r;
	endproperty
	a_diag_quiet: assert property (p_diag_quiet) else $error("diag pass set error");

	c_diag: cover property (@(posedge sys_clk) disable iff (srst)
		st_r == SIL_RUN && fault && diag_active);
	c_sel: cover property (@(posedge sys_clk) disable iff (srst)
		st_r == SIL_RUN && fault && !diag_active);
	c_enh: cover property (@(posedge sys_clk) disable iff (srst)
		st_r == SIL_RUN && fault && enhanced && !diag_active);
	c_gap: cover property (@(posedge sys_clk) disable iff (srst)
		st_r == SIL_GAP && cnt_r == 32'd0);
	c_break: cover property (@(posedge sys_clk) disable iff (srst)
		st_r == SIL_BREAK && cnt_r == 32'd0);
endmodule

// >>> logic/sil_map.svh
// Offsets-free constant map for the SCSI ID and error LED block
`ifndef SIL_MAP_SVH
`define SIL_MAP_SVH

// ****************************************
// Timing (40 MHz system clock)
// ****************************************
`define SIL_CLK_HZ 40000000
`define SIL_T_ONE_MS 1000
`define SIL_T_ZERO_MS 500
`define SIL_T_GAP_MS 1000
`define SIL_T_BREAK_MS 2000
`define SIL_CYC(ms) ((`SIL_CLK_HZ / 1000) * (ms))

// ****************************************
// Error codes
// ****************************************
`define SIL_ERR_DMA 4'h0
`define SIL_ERR_CTL 4'h1
`define SIL_ERR_LOOP 4'h2
`define SIL_ERR_LOOP_DMA 4'h3
`define SIL_ERR_FLAG 4'h4
`define SIL_ERR_SEL_LOW 4'h5
`define SIL_ERR_OWN_ID 4'h6
`define SIL_ERR_MANY 4'h7
`define SIL_ERR_PARITY 4'h8
`define SIL_ERR_SEL_FLAG 4'h9

// ****************************************
// Field positions
// ****************************************
`define SIL_CODE_MSB 3
`define SIL_ID_W 3

`endif

// >>> logic/sil_pkg.sv
// Types for the SCSI ID and error LED block
package sil_pkg;
	typedef enum logic [2:0] {
		SIL_BOOT = 3'b000,
		SIL_RUN = 3'b001,
		SIL_DARK = 3'b010,
		SIL_GAP = 3'b011,
		SIL_BREAK = 3'b100
	} sil_led_e;
	typedef logic [3:0] sil_code_t;
endpackage

// >>> logic/sil_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module sil_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_r, s2_r, s3_r, out_r;
	logic [W-1:0] out_nxt;

	always_comb begin
		out_nxt = out_r;
		// First stage is read only by the second
		if (s2_r == s3_r) begin
			out_nxt = s3_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			out_r <= '0;
		end else begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
			out_r <= out_nxt;
		end
	end

	assign dout = out_r;
endmodule

// >>> logic/sil_onehot.sv
// Three-bit ID to eight-bit one-hot pattern
`timescale 1ns/1ps
module sil_onehot (
	// Number in
	input wire logic [2:0] id,
	// Pattern out
	output logic [7:0] mask
);
	always_comb begin
		mask = 8'h01 << id;
	end
endmodule

// >>> tb/sil_panel.sv
// Switch block and front-panel LED model
`timescale 1ns/1ps
module sil_panel (
	// Clock
	input wire logic sys_clk,
	// Switch setting chosen by the bench
	input wire logic [2:0] id_set,
	// Board pins
	output logic [3:0] sw,
	input wire logic led_on
);
	logic prev = 1'b1;
	int cnt = 0;
	logic [31:0] runs[$];
	// ****************************************
	// Switches
	// ****************************************
	// Switch 4 opposes switch 3 so a stray use of it shows
	assign sw = {id_set, ~id_set[0]};
	// ****************************************
	// LED run logger
	// ****************************************
	// Each run is pushed as {level, length in cycles}
	always @(posedge sys_clk) begin
		if (led_on !== prev) begin
			runs.push_back({prev, cnt[30:0]});
			cnt = 1;
		end else begin
			cnt = cnt + 1;
		end
		prev = led_on;
	end
endmodule

// >>> tb/tb.sv
// Self-checking testbench for the status block
`timescale 1ns/1ps
module tb;
	logic sys_clk, srst, diag_active, diag_fail, sel_check, sel_line, flag_err;
	logic enhanced, parity_err, sel_flag, led_on, err_active;
	logic [1:0] diag_code;
	logic [2:0] id_set;
	logic [3:0] sw, err_code;
	logic [7:0] sel_data, id_mask;
	int failures = 0;
	int tests_run = 0;
	// {data, line, flag, enhanced, parity, select flag} for codes 4..9
	logic [12:0] sel_tab [6] = '{13'h139, 13'h121, 13'h031, 13'h171, 13'h137, 13'h134};
	logic [31:0] exp_runs [9] = '{32'h5, 32'h8000000a, 32'h5, 32'h8000000a, 32'ha,
		32'h8000000a, 32'h5, 32'h80000014, 32'h5};
	// ****************************************
	// Design and partner
	// ****************************************
	// Short intervals keep the run small
	sil_status #(.ONE_CYC(10), .ZERO_CYC(5), .GAP_CYC(10), .BREAK_CYC(20)) sil_status_inst (
		.sys_clk(sys_clk), .srst(srst), .sw(sw), .diag_active(diag_active),
		.diag_fail(diag_fail), .diag_code(diag_code), .sel_check(sel_check),
		.sel_data(sel_data), .sel_line(sel_line), .flag_err(flag_err), .enhanced(enhanced),
		.parity_err(parity_err), .sel_flag(sel_flag), .id_mask(id_mask), .led_on(led_on),
		.err_active(err_active), .err_code(err_code));
	sil_panel sil_panel_inst (.sys_clk(sys_clk), .id_set(id_set), .sw(sw), .led_on(led_on));
	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("Counts: compared=%0d mismatched=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic boot(input logic [2:0] id);
		@(posedge sys_clk);
		srst <= 1'b1;
		id_set <= id;
		diag_active <= 1'b0;
		diag_fail <= 1'b0;
		sel_check <= 1'b0;
		tick(3);
		chk(id_mask, 8'h01);
		chk(err_active, 1'b0);
		chk(led_on, 1'b1);
		@(posedge sys_clk);
		srst <= 1'b0;
		diag_active <= 1'b1;
		tick(8);
		chk(led_on, 1'b1);
		chk(id_mask, 8'h01 << id);
	endtask
	task automatic pulse(input logic [12:0] v);
		@(posedge sys_clk);
		{sel_data, sel_line, flag_err, enhanced, parity_err, sel_flag} <= v;
		sel_check <= 1'b1;
		@(posedge sys_clk);
		sel_check <= 1'b0;
		tick(3);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_id();
		for (int i = 0; i < 8; i++) begin
			boot(i[2:0]);
			@(posedge sys_clk);
			diag_active <= 1'b0;
			id_set <= ~i[2:0];
			tick(10);
			chk(id_mask, 8'h01 << i);
		end
		$display("test id done");
	endtask
	task automatic t_diag();
		for (int c = 0; c < 4; c++) begin
			boot(3'h3);
			@(posedge sys_clk);
			diag_fail <= 1'b1;
			diag_code <= c[1:0];
			tick(3);
			chk(err_code, c);
			chk(err_active, 1'b1);
		end
		$display("test diag done");
	endtask
	task automatic t_blink();
		boot(3'h3);
		sil_panel_inst.runs.delete();
		@(posedge sys_clk);
		diag_fail <= 1'b1;
		diag_code <= 2'h2;
		tick(3);
		@(posedge sys_clk);
		diag_code <= 2'h1;
		for (int k = 0; k < 400 && sil_panel_inst.runs.size() < 10; k++) tick(1);
		if (sil_panel_inst.runs.size() < 10) begin
			failures++;
			end_sim();
		end
		for (int j = 0; j < 9; j++) begin
			chk(sil_panel_inst.runs[j + 1], exp_runs[j]);
		end
		chk(err_code, 4'h2);
		$display("test blink done");
	endtask
	task automatic t_sel();
		for (int i = 0; i < 6; i++) begin
			boot(3'h3);
			pulse(13'h031);
			chk(err_active, 1'b0);
			@(posedge sys_clk);
			diag_active <= 1'b0;
			pulse(13'h131);
			chk(err_active, 1'b0);
			pulse(13'h135);
			chk(err_active, 1'b0);
			// Enhanced part ignores the basic flag and select line
			pulse(13'h12d);
			chk(err_active, 1'b0);
			pulse(sel_tab[i]);
			chk(err_code, 4 + i);
			chk(led_on, 1'b0);
			pulse(sel_tab[(i + 1) % 6]);
			chk(err_code, 4 + i);
		end
		$display("test sel done");
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		srst = 1'b1;
		id_set = 3'h0;
		diag_active = 1'b0;
		diag_fail = 1'b0;
		diag_code = 2'h0;
		sel_check = 1'b0;
		{sel_data, sel_line, flag_err, enhanced, parity_err, sel_flag} = 13'h0;
		t_id();
		t_diag();
		t_blink();
		t_sel();
		end_sim();
	end
endmodule
